// ==== inc/dlgc_defines.vh ====
// dlgc_defines.vh: offsets, field positions, reset values and codes
// for the loop gain configuration register bank
// assumes: included by bare name from the design files
`ifndef DLGC_DEFINES_VH
`define DLGC_DEFINES_VH

// register offsets (8-bit address space)
`define DLGC_ADDR_DAMPING      8'h6b
`define DLGC_ADDR_DET_GAIN     8'h6c
`define DLGC_ADDR_STATUS       8'h6e

// reset values
`define DLGC_DAMPING_RESET     8'h13
`define DLGC_DET_GAIN_RESET    8'hc2

// field positions
`define DLGC_DAMP_CODE_MSB     2
`define DLGC_DAMP_CODE_LSB     0
`define DLGC_LOW_GAIN_MSB      6
`define DLGC_LOW_GAIN_LSB      4
`define DLGC_AUTO_EN_BIT       7
`define DLGC_ANA_GAIN_MSB      6
`define DLGC_ANA_GAIN_LSB      4
`define DLGC_DIG_GAIN_MSB      2
`define DLGC_DIG_GAIN_LSB      0

// status word fields
`define DLGC_STAT_EN_BIT       4
`define DLGC_STAT_GAIN_MSB     2
`define DLGC_STAT_GAIN_LSB     0

// writable bit masks (unused bits read zero)
`define DLGC_DAMPING_MASK      8'h77
`define DLGC_DET_GAIN_MASK     8'hf7

// bandwidth select codes
`define DLGC_BW_18HZ           2'h0
`define DLGC_BW_35HZ           2'h1
`define DLGC_BW_70HZ           2'h2

// locking mode codes
`define DLGC_MODE_DIGITAL      2'h0
`define DLGC_MODE_ANALOG       2'h1
`define DLGC_MODE_ANALOG_8K    2'h2

// damping factor in tenths
`define DLGC_DAMP_NONE         8'h00
`define DLGC_DAMP_1P2          8'h0c
`define DLGC_DAMP_2P5          8'h19
`define DLGC_DAMP_5            8'h32
`define DLGC_DAMP_10           8'h64
`define DLGC_DAMP_20           8'hc8

`endif

// ==== hdl/dlgc_damping_decode.v ====
// dlgc_damping_decode.v: turns a 3-bit damping code and bandwidth
// select into a damping factor in tenths
// assumes: purely combinational, driven from registered inputs
`timescale 1ns/1ps
`default_nettype none
`include "dlgc_defines.vh"

module dlgc_damping_decode (
  input  wire [2:0] code_in,
  input  wire [1:0] bandwidth_in,
  output reg  [7:0] factor_out,
  output reg        valid_out
);

  // code and bandwidth lookup
  always @* begin
    factor_out = `DLGC_DAMP_NONE;
    valid_out  = 1'b1;
    case (code_in)
      3'h1: factor_out = `DLGC_DAMP_1P2;
      3'h2: factor_out = `DLGC_DAMP_2P5;
      3'h3: factor_out = `DLGC_DAMP_5;
      3'h4: begin
        if (bandwidth_in == `DLGC_BW_18HZ) begin
          factor_out = `DLGC_DAMP_5;
        end else begin
          factor_out = `DLGC_DAMP_10;
        end
      end
      3'h5: begin
        case (bandwidth_in)
          `DLGC_BW_18HZ: factor_out = `DLGC_DAMP_5;
          `DLGC_BW_35HZ: factor_out = `DLGC_DAMP_10;
          default:       factor_out = `DLGC_DAMP_20;
        endcase
      end
      default: valid_out = 1'b0; // undefined code
    endcase
  end

endmodule // dlgc_damping_decode
`default_nettype wire

// ==== hdl/dlgc_regs.v ====
// dlgc_regs.v: configuration register bank for two loops: damping
// code of the first loop and secondary detector gain of the second
// assumes: single clock, synchronous active-high reset, one-cycle
// strobes from a simple master, read data valid the cycle after
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "dlgc_defines.vh"

module dlgc_regs (
  input  wire       ref_clk_in,
  input  wire       rst_in,
  input  wire [7:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  input  wire [1:0] bandwidth_sel_in,
  input  wire [1:0] lock_mode_in,
  output reg  [7:0] pll1_damping_factor_out,
  output reg        pll1_damping_valid_out,
  output reg  [2:0] pll1_analog_low_rate_gain_out,
  output reg        pll2_detector_enable_out,
  output reg  [2:0] pll2_detector_gain_out
);

  // register storage and next values
  reg  [7:0] pll1_damping_config_q;
  reg  [7:0] pll1_damping_config_d;
  reg  [7:0] pll2_detector_gain_config_q;
  reg  [7:0] pll2_detector_gain_config_d;

  // address decode
  wire       hit_damping;
  wire       hit_det_gain;
  wire       hit_status;
  wire       wr_damping;
  wire       wr_det_gain;

  // register fields
  wire [2:0] pll1_damping_code;
  wire [2:0] pll1_analog_low_rate_gain;
  wire       pll2_auto_gain_enable;
  wire [2:0] pll2_analog_path_gain;
  wire [2:0] pll2_digital_path_gain;

  // damping decoder inputs and results
  reg  [1:0] bandwidth_norm;
  wire [7:0] factor_w;
  wire       valid_w;

  // locking mode flags
  reg        mode_digital;
  reg        mode_analog;
  reg        mode_analog_low;

  // detector selection
  reg        det_en_d;
  reg  [2:0] det_gain_d;

  // read path
  reg  [7:0] status_d;
  reg  [7:0] rdata_d;

  // which register the bus points at
  assign hit_damping  = (addr_in == `DLGC_ADDR_DAMPING);
  assign hit_det_gain = (addr_in == `DLGC_ADDR_DET_GAIN);
  assign hit_status   = (addr_in == `DLGC_ADDR_STATUS);

  // status place is read-only, so only two write enables
  assign wr_damping  = wr_in & hit_damping;
  assign wr_det_gain = wr_in & hit_det_gain;

  // field slices of the stored words
  assign pll1_damping_code =
    pll1_damping_config_q[`DLGC_DAMP_CODE_MSB:`DLGC_DAMP_CODE_LSB];
  assign pll1_analog_low_rate_gain =
    pll1_damping_config_q[`DLGC_LOW_GAIN_MSB:`DLGC_LOW_GAIN_LSB];
  assign pll2_auto_gain_enable =
    pll2_detector_gain_config_q[`DLGC_AUTO_EN_BIT];
  assign pll2_analog_path_gain =
    pll2_detector_gain_config_q[`DLGC_ANA_GAIN_MSB:`DLGC_ANA_GAIN_LSB];
  assign pll2_digital_path_gain =
    pll2_detector_gain_config_q[`DLGC_DIG_GAIN_MSB:`DLGC_DIG_GAIN_LSB];

  // next value of the damping word
  // unused bits dropped
  always @* begin
    pll1_damping_config_d = pll1_damping_config_q;
    if (wr_damping) begin
      pll1_damping_config_d = wdata_in & `DLGC_DAMPING_MASK;
    end
  end

  // next value of the detector gain word
  // bit 3 dropped
  always @* begin
    pll2_detector_gain_config_d = pll2_detector_gain_config_q;
    if (wr_det_gain) begin
      pll2_detector_gain_config_d = wdata_in & `DLGC_DET_GAIN_MASK;
    end
  end

  // register storage, back to default words on reset
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pll1_damping_config_q       <= `DLGC_DAMPING_RESET;
      pll2_detector_gain_config_q <= `DLGC_DET_GAIN_RESET;
    end else begin
      pll1_damping_config_q       <= pll1_damping_config_d;
      pll2_detector_gain_config_q <= pll2_detector_gain_config_d;
    end
  end

  // bandwidth code 3 is taken as the widest setting
  always @* begin
    case (bandwidth_sel_in)
      `DLGC_BW_18HZ: bandwidth_norm = `DLGC_BW_18HZ;
      `DLGC_BW_35HZ: bandwidth_norm = `DLGC_BW_35HZ;
      default:       bandwidth_norm = `DLGC_BW_70HZ;
    endcase
  end

  dlgc_damping_decode u_decode (
    .code_in      (pll1_damping_code),
    .bandwidth_in (bandwidth_norm),
    .factor_out   (factor_w),
    .valid_out    (valid_w)
  );

  // one flag per locking mode; code 3 falls back to digital
  always @* begin
    mode_digital    = 1'b0;
    mode_analog     = 1'b0;
    mode_analog_low = 1'b0;
    case (lock_mode_in)
      `DLGC_MODE_ANALOG:    mode_analog     = 1'b1;
      `DLGC_MODE_ANALOG_8K: mode_analog_low = 1'b1;
      default:              mode_digital    = 1'b1;
    endcase
  end

  always @* begin
    det_en_d = 1'b0;
    if (pll2_auto_gain_enable) begin
      det_en_d = 1'b1;
    end
  end

  // gain pick; the digital field is the fallback
  always @* begin
    det_gain_d = pll2_digital_path_gain;
    if (pll2_auto_gain_enable) begin
      if (mode_analog) begin
        det_gain_d = pll2_analog_path_gain;
      end
      // low-rate gain lives outside this bank
      if (mode_analog_low) begin
        det_gain_d = 3'h0;
      end
      if (mode_digital) begin
        det_gain_d = pll2_digital_path_gain;
      end
    end
  end

  // status word: detector enable and selected gain, rest zero
  always @* begin
    status_d                                         = 8'h00;
    status_d[`DLGC_STAT_EN_BIT]                      = det_en_d;
    status_d[`DLGC_STAT_GAIN_MSB:`DLGC_STAT_GAIN_LSB] = det_gain_d;
  end

  // read mux
  // unused bits and places read zero
  always @* begin
    rdata_d = 8'h00;
    if (hit_damping) begin
      rdata_d = pll1_damping_config_q;
    end
    if (hit_det_gain) begin
      rdata_d = pll2_detector_gain_config_q;
    end
    if (hit_status) begin
      rdata_d = status_d;
    end
  end

  // read data, present only in the cycle after the strobe
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rdata_d;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pll1_damping_factor_out <= 8'h00;
    end else begin
      pll1_damping_factor_out <= factor_w;
    end
  end

  // codes 0, 6 and 7 flagged as undefined
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pll1_damping_valid_out <= 1'b0;
    end else begin
      pll1_damping_valid_out <= valid_w;
    end
  end

  // low-rate analog gain field handed on as stored
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pll1_analog_low_rate_gain_out <= 3'h0;
    end else begin
      pll1_analog_low_rate_gain_out <= pll1_analog_low_rate_gain;
    end
  end

  // registered detector enable
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pll2_detector_enable_out <= 1'b0;
    end else begin
      pll2_detector_enable_out <= det_en_d;
    end
  end

  // registered detector gain
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pll2_detector_gain_out <= 3'h0;
    end else begin
      pll2_detector_gain_out <= det_gain_d;
    end
  end

endmodule // dlgc_regs
`default_nettype wire

// ==== testbench/dlgc_regs_sva.sv ====
// dlgc_regs_sva.sv: port checker for the loop gain register bank
// assumes: bound to dlgc_regs, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module dlgc_regs_sva (
  input wire logic       ref_clk_in,
  input wire logic       rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [1:0] bandwidth_sel_in,
  input wire logic [1:0] lock_mode_in,
  input wire logic [7:0] pll1_damping_factor_out,
  input wire logic       pll1_damping_valid_out,
  input wire logic [2:0] pll1_analog_low_rate_gain_out,
  input wire logic       pll2_detector_enable_out,
  input wire logic [2:0] pll2_detector_gain_out
);
  logic [7:0] g_q;  // shadow of detector gain register
  logic [7:0] d_q;  // shadow of damping register, unused bits zero
  logic [1:0] up_q; // edges since reset release
  // shadow registers and reset age
  always_ff @(posedge ref_clk_in) begin
    up_q <= rst_in ? 2'h0 : {up_q[0], 1'h1};
    g_q  <= rst_in ? 8'hc2 : (wr_in && addr_in == 8'h6c) ? wdata_in : g_q;
    d_q  <= rst_in ? 8'h13 : (wr_in && addr_in == 8'h6b) ? (wdata_in & 8'h77) : d_q;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_wide_damp: assert property (pll1_damping_factor_out == 8'hc8 |->
    $past(bandwidth_sel_in[1])) else $error("factor 20 below 70 Hz");
  a_code_valid: assert property (up_q[1] |-> pll1_damping_valid_out ==
    ($past(d_q[2:0]) != 3'h0 && $past(d_q[2:0]) < 3'h6))
    else $error("code valid flag wrong");
  a_det_off: assert property (up_q[1] && !$past(g_q[7]) |->
    !pll2_detector_enable_out) else $error("detector on while auto off");
  a_det_on: assert property (up_q[1] && $past(g_q[7]) |->
    pll2_detector_enable_out) else $error("detector off while auto on");
  a_analog_gain: assert property (up_q[1] && $past(g_q[7]) &&
    $past(lock_mode_in) == 2'h1 |-> pll2_detector_gain_out == $past(g_q[6:4]))
    else $error("analog gain wrong");
  a_digital_gain: assert property (up_q[1] && (!$past(g_q[7]) ||
    $past(lock_mode_in) == 2'h0) |-> pll2_detector_gain_out == $past(g_q[2:0]))
    else $error("digital gain wrong");
  a_gain_readback: assert property ($past(rd_in) && $past(addr_in) == 8'h6c |->
    rdata_out == ($past(g_q) & 8'hf7)) else $error("gain readback wrong");
  a_damp_readback: assert property ($past(rd_in) && $past(addr_in) == 8'h6b |->
    rdata_out == $past(d_q)) else $error("damping readback wrong");
  a_low_gain: assert property (up_q[1] |->
    pll1_analog_low_rate_gain_out == $past(d_q[6:4])) else $error("low rate gain wrong");
  a_idle_read: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read cycle");
endmodule // dlgc_regs_sva
bind dlgc_regs dlgc_regs_sva u_sva (.*);
`default_nettype wire

// ==== testbench/dlgc_regs_test.sv ====
// dlgc_regs_test.sv: self-checking bench for the loop gain register bank
// assumes: dlgc_regs with its checker bound, 250 MHz clock
`timescale 1ns/1ps
`default_nettype none
module dlgc_regs_test;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, vld, en;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, fac;
  logic [1:0] bw = 2'h0, mode = 2'h0;
  logic [2:0] gain, lg;
  int         fail_count = 0, checked = 0;
  // rows: bandwidth nibble, damping code nibble, expected factor byte
  logic [15:0] tf [0:21] = '{16'h0000, 16'h1000, 16'h2000, 16'h010c, 16'h110c, 16'h210c,
    16'h0219, 16'h1219, 16'h2219, 16'h0332, 16'h1332, 16'h2332, 16'h0432, 16'h1464,
    16'h2464, 16'h3464, 16'h0532, 16'h1564, 16'h25c8, 16'h35c8, 16'h0600, 16'h2700};
  always #2 clk = ~clk;
  dlgc_regs dut (.ref_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wd), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .bandwidth_sel_in(bw), .lock_mode_in(mode),
    .pll1_damping_factor_out(fac), .pll1_damping_valid_out(vld),
    .pll1_analog_low_rate_gain_out(lg), .pll2_detector_enable_out(en),
    .pll2_detector_gain_out(gain));
  // compare and count
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  task automatic wrt(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask
  task automatic setm(logic [1:0] m);
    @(posedge clk);
    mode <= m;
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // damping code table across bandwidths, undefined codes included
    for (int i = 0; i < 22; i++) begin
      @(posedge clk);
      bw <= tf[i][13:12];
      wrt(8'h6b, {5'h00, tf[i][10:8]});
      @(posedge clk);
      #1 chk("factor", fac, tf[i][7:0]);
      chk("valid", 8'(vld), 8'(tf[i][10:8] != 3'h0 && tf[i][10:8] < 3'h6));
    end
    // unused bits and unmapped place
    wrt(8'h6b, 8'hff);
    rdc(8'h6b, 8'h77);
    chk("low gain", 8'(lg), 8'h07);
    wrt(8'h6c, 8'hff);
    rdc(8'h6c, 8'hf7);
    wrt(8'h20, 8'h5a);
    rdc(8'h20, 8'h00);
    // detector with auto gain off, then each locking mode
    wrt(8'h6c, 8'h35);
    setm(2'h1);
    chk("enable", 8'(en), 8'h00);
    chk("gain", 8'(gain), 8'h05);
    wrt(8'h6c, 8'hb5);
    setm(2'h0);
    chk("gain", 8'(gain), 8'h05);
    setm(2'h1);
    chk("enable", 8'(en), 8'h01);
    chk("gain", 8'(gain), 8'h03);
    setm(2'h2);
    chk("gain", 8'(gain), 8'h00);
    rdc(8'h6e, 8'h10);
    setm(2'h3);
    chk("gain", 8'(gain), 8'h05);
    wrt(8'h6e, 8'hff);
    rdc(8'h6e, 8'h15);
    // reset again mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h6b, 8'h13);
    rdc(8'h6c, 8'hc2);
    chk("low gain", 8'(lg), 8'h01);
    chk("enable", 8'(en), 8'h01);
    chk("gain", 8'(gain), 8'h02);
    finish_test;
  end
  task finish_test;
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
endmodule // dlgc_regs_test
`default_nettype wire
